// ### verilog/nand_boot_pkg.sv
// Behaviour
// - Host pulses read enable once per word.
// - Chip enable high or command stops streaming.
// - Host records bad markers before any erase.
// - Program or erase failure makes block bad.
// - Erase/program replace block, read uses correction.
package nand_boot_pkg;
   localparam int        PAGE_BYTES      = 528;
   localparam int        SPARE_MARK_IDX  = 517;
   localparam int        PAGES_PER_BLOCK = 32;
   localparam int        TOTAL_PAGES     = 65536;
   localparam int        BLOCKS          = 2048;
   localparam int        BLOCK_W         = 11;
   localparam logic [7:0] ERASED_BYTE    = 8'hFF;
   localparam int        FIFO_DEPTH      = 16;
   localparam int        CLK_NS          = 10;
   localparam int        RE_LOW_NS       = 30;
   localparam int        RE_HIGH_NS      = 20;
   localparam int        RE_LOW_CYC      = (RE_LOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int        RE_HIGH_CYC     = (RE_HIGH_NS + CLK_NS - 1) / CLK_NS;

   typedef struct packed {
      logic [7:0] data;
      logic       page_end;
   } boot_word_s;

   typedef enum logic [1:0] {FAIL_READ, FAIL_PROGRAM, FAIL_ERASE} fail_kind_e;

   typedef struct packed {
      fail_kind_e         kind;
      logic [BLOCK_W-1:0] block;
   } fail_report_s;
endpackage

// ### verilog/nand_boot_reader.sv
`timescale 1ns/100ps
module boot_fifo
   import nand_boot_pkg::*;
#(
   parameter int WIDTH = 9,
   parameter int DEPTH = FIFO_DEPTH
) (
   input  wire logic             sys_clk,
   input  wire logic             sys_rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
   logic [AW:0]      cnt_q, cnt_d;
   logic             push, pop;

   always_comb begin
      push  = in_valid && in_ready;
      pop   = out_valid && out_ready;
      wr_d  = push ? wr_q + 1'b1 : wr_q;
      rd_d  = pop ? rd_q + 1'b1 : rd_q;
      cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         wr_q  <= wr_d;
         rd_q  <= rd_d;
         cnt_q <= cnt_d;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end

   assign in_ready  = (cnt_q != DEPTH[AW:0]);
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem[rd_q];
endmodule

module nand_boot_reader
   import nand_boot_pkg::*;
#(
   parameter int PAGES = TOTAL_PAGES,
   parameter int DEPTH = FIFO_DEPTH
) (
   input  wire logic               sys_clk,
   input  wire logic               sys_rst,
   input  wire logic               seq_enable,
   input  wire logic               stop_req,
   output logic                    ce_n_q,
   output logic                    re_n_q,
   output logic                    we_n_q,
   output logic                    cle_q,
   output logic                    ale_q,
   input  wire logic               rb_n,
   input  wire logic [7:0]         io_in,
   output logic      [7:0]         io_out_q,
   output logic                    io_oe_q,
   output boot_word_s              word_out,
   output logic                    word_valid,
   input  wire logic               word_ready,
   output logic                    busy_q,
   output logic                    scan_done_q,
   output logic                    bad_event_q,
   output logic      [BLOCK_W-1:0] bad_block_q,
   input  wire logic               fail_valid,
   input  wire fail_report_s       fail_in,
   output logic                    replace_req_q,
   output logic                    ecc_req_q,
   input  wire logic [BLOCK_W-1:0] query_block,
   output logic                    query_bad_q
);
   typedef enum logic [2:0] {S_WAIT_HIGH, S_WAIT_LOW, S_RE_LOW, S_RE_HIGH, S_DONE} state_e;

   state_e       state_q, state_d;
   logic [3:0]   cnt_q, cnt_d;
   logic [9:0]   byte_q, byte_d;
   logic [16:0]  page_q, page_d;
   logic         ce_n_d, re_n_d, scan_d, capture, mark_hit, fifo_ready;
   logic         bad_tab_q [BLOCKS];
   boot_word_s   cap_word;

   function automatic logic [BLOCK_W-1:0] block_of(input logic [16:0] page);
      block_of = page[BLOCK_W+4:5];
   endfunction

   always_comb begin
      state_d  = state_q;
      cnt_d    = cnt_q;
      byte_d   = byte_q;
      page_d   = page_q;
      ce_n_d   = 1'b0;
      re_n_d   = 1'b1;
      scan_d   = scan_done_q;
      capture  = 1'b0;
      cap_word = '{data: io_in, page_end: (byte_q == 10'(PAGE_BYTES - 1))};
      mark_hit = 1'b0;
      case (state_q)
         S_WAIT_HIGH: begin
            if (rb_n) begin
               state_d = S_RE_HIGH;
               cnt_d   = '0;
               byte_d  = '0;
            end
         end
         S_WAIT_LOW: begin
            if (!rb_n) begin
               state_d = S_WAIT_HIGH;
            end
         end
         S_RE_HIGH: begin
            if (cnt_q >= 4'(RE_HIGH_CYC - 1) && fifo_ready) begin // Stall keeps back-pressure honest
               state_d = S_RE_LOW;
               cnt_d   = '0;
               re_n_d  = 1'b0;
            end else begin
               cnt_d = (cnt_q >= 4'(RE_HIGH_CYC - 1)) ? cnt_q : cnt_q + 4'h1;
            end
         end
         S_RE_LOW: begin
            if (cnt_q == 4'(RE_LOW_CYC - 1)) begin
               capture = 1'b1;
               cnt_d   = '0;
               mark_hit = (byte_q == 10'(SPARE_MARK_IDX)) && (page_q[4:1] == 4'h0)
                          && (io_in != ERASED_BYTE);
               if (byte_q == 10'(PAGE_BYTES - 1)) begin
                  page_d = page_q + 17'h1;
                  if (!seq_enable || page_q == 17'(PAGES - 1)) begin
                     state_d = S_DONE;
                     scan_d  = (page_q == 17'(PAGES - 1));
                  end else begin
                     state_d = S_WAIT_LOW;
                  end
               end else begin
                  byte_d  = byte_q + 10'h1;
                  state_d = S_RE_HIGH;
               end
            end else begin
               re_n_d = 1'b0;
               cnt_d  = cnt_q + 4'h1;
            end
         end
         S_DONE: begin
            ce_n_d = 1'b1;
         end
         default: state_d = S_DONE;
      endcase
      if (stop_req) begin
         state_d = S_DONE;
         ce_n_d  = 1'b1;
         re_n_d  = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q       <= S_WAIT_HIGH;
         cnt_q         <= '0;
         byte_q        <= '0;
         page_q        <= '0;
         ce_n_q        <= 1'b1;
         re_n_q        <= 1'b1;
         busy_q        <= 1'b1;
         scan_done_q   <= 1'b0;
         bad_event_q   <= 1'b0;
         bad_block_q   <= '0;
         replace_req_q <= 1'b0;
         ecc_req_q     <= 1'b0;
         query_bad_q   <= 1'b0;
         for (int i = 0; i < BLOCKS; i++) begin
            bad_tab_q[i] <= 1'b0;
         end
      end else begin
         state_q       <= state_d;
         cnt_q         <= cnt_d;
         byte_q        <= byte_d;
         page_q        <= page_d;
         ce_n_q        <= ce_n_d;
         re_n_q        <= re_n_d;
         busy_q        <= (state_d != S_DONE);
         scan_done_q   <= scan_d;
         bad_event_q   <= mark_hit;
         replace_req_q <= fail_valid && (fail_in.kind != FAIL_READ);
         ecc_req_q     <= fail_valid && (fail_in.kind == FAIL_READ);
         query_bad_q   <= bad_tab_q[query_block];
         if (mark_hit) begin
            bad_block_q             <= block_of(page_q);
            bad_tab_q[block_of(page_q)] <= 1'b1;
         end
         if (fail_valid && fail_in.kind != FAIL_READ) begin
            bad_tab_q[fail_in.block] <= 1'b1;
         end
      end
   end

   // Host never issues commands here, so the bus stays released
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         we_n_q   <= 1'b1;
         cle_q    <= 1'b0;
         ale_q    <= 1'b0;
         io_out_q <= 8'h00;
         io_oe_q  <= 1'b0;
      end else begin
         we_n_q   <= 1'b1;
         cle_q    <= 1'b0;
         ale_q    <= 1'b0;
         io_out_q <= 8'h00;
         io_oe_q  <= 1'b0;
      end
   end

   boot_fifo #(.WIDTH($bits(boot_word_s)), .DEPTH(DEPTH)) u_fifo (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .in_valid  (capture),
      .in_ready  (fifo_ready),
      .in_data   (cap_word),
      .out_valid (word_valid),
      .out_ready (word_ready),
      .out_data  (word_out)
   );

   sequence s_re_pulse;
      !re_n_q [*3] ##1 re_n_q;
   endsequence

   property p_re_pulse;
      @(posedge sys_clk) disable iff (sys_rst || stop_req) ($fell(re_n_q) && !stop_req) |-> s_re_pulse;
   endproperty
   a_re_pulse: assert property (p_re_pulse) else $error("read enable pulse width wrong");

   property p_re_ready;
      @(posedge sys_clk) disable iff (sys_rst) $fell(re_n_q) |-> !ce_n_q && fifo_ready;
   endproperty
   a_re_ready: assert property (p_re_ready) else $error("read pulse without select or room");

   property p_stop;
      @(posedge sys_clk) disable iff (sys_rst) stop_req |=> ce_n_q && re_n_q && !busy_q;
   endproperty
   a_stop: assert property (p_stop) else $error("stop did not release chip enable");

   property p_mark;
      @(posedge sys_clk) disable iff (sys_rst)
         (capture && byte_q == 10'(SPARE_MARK_IDX) && page_q[4:1] == 4'h0 && io_in != ERASED_BYTE)
         |=> bad_event_q ##1 query_block != bad_block_q || query_bad_q;
   endproperty
   a_mark: assert property (p_mark) else $error("bad marker not recorded");

   property p_fail;
      @(posedge sys_clk) disable iff (sys_rst)
         (fail_valid && fail_in.kind != FAIL_READ) |=> replace_req_q && !ecc_req_q;
   endproperty
   a_fail: assert property (p_fail) else $error("failure did not request replacement");

   property p_ecc;
      @(posedge sys_clk) disable iff (sys_rst)
         (fail_valid && fail_in.kind == FAIL_READ) |=> ecc_req_q && !replace_req_q;
   endproperty
   a_ecc: assert property (p_ecc) else $error("read error did not request correction");
endmodule

// ### verification/nand_autoread_model.sv
`timescale 1ns/100ps
module nand_autoread_model #(
   parameter int PAGES = 4,
   parameter int BUSY  = 20
) (
   input  wire logic       sys_clk,
   input  wire logic       power_rst,
   input  wire logic       seq_option,
   input  wire logic       mark_bad,
   input  wire logic       ce_n,
   input  wire logic       re_n,
   output logic            rb_n,
   output logic      [7:0] io
);
   int         page_q, idx_q, wait_q;
   logic       re_prev_q, ce_prev_q, halted_q;
   logic [7:0] last_q, cur;
   // Deselected or idle bus shows the inverse of the last byte, never a stale copy
   always_comb begin
      cur = 8'(idx_q + page_q * 7);
      if (idx_q == 517) cur = (mark_bad && page_q == 0) ? 8'h00 : 8'hFF;
      io = (!ce_n && !re_n && !halted_q) ? cur : ~last_q;
      rb_n = (wait_q == 0);
   end
   always_ff @(posedge sys_clk or posedge power_rst) begin
      if (power_rst) begin
         page_q <= 0;
         idx_q <= 0;
         wait_q <= BUSY;
         re_prev_q <= 1'b1;
         ce_prev_q <= 1'b1;
         halted_q <= 1'b0;
         last_q <= 8'h00;
      end else begin
         re_prev_q <= re_n;
         ce_prev_q <= ce_n;
         if (!re_n && !ce_n) last_q <= cur;
         if (wait_q != 0) wait_q <= wait_q - 1;
         if (ce_n && !ce_prev_q) begin
            halted_q <= 1'b1;
            wait_q <= 0;
         end else if (re_n && !re_prev_q && !halted_q) begin
            if (idx_q != 527) begin
               idx_q <= idx_q + 1;
            end else if (seq_option && page_q < PAGES - 1) begin
               idx_q <= 0;
               page_q <= page_q + 1;
               wait_q <= BUSY;
            end else begin
               halted_q <= 1'b1;
            end
         end
      end
   end
endmodule

// ### verification/test_nand_boot_reader.sv
`timescale 1ns/100ps
module test_nand_boot_reader
   import nand_boot_pkg::*;
;
   logic               sys_clk, sys_rst, seq_enable, stop_req, word_ready, fail_valid, mark_bad;
   logic               ce_n_q, re_n_q, we_n_q, cle_q, ale_q, rb_n, io_oe_q, word_valid, busy_q;
   logic               scan_done_q, bad_event_q, replace_req_q, ecc_req_q, query_bad_q;
   logic [7:0]         io_in, io_out_q;
   logic [BLOCK_W-1:0] bad_block_q, query_block;
   boot_word_s         word_out;
   fail_report_s       fail_in;
   int                 n_fail, compares, cycles, n_bad, lows;

   nand_boot_reader #(.PAGES(4)) nand_boot_reader_inst (.sys_clk, .sys_rst, .seq_enable, .stop_req,
      .ce_n_q, .re_n_q, .we_n_q, .cle_q, .ale_q, .rb_n, .io_in, .io_out_q, .io_oe_q, .word_out,
      .word_valid, .word_ready, .busy_q, .scan_done_q, .bad_event_q, .bad_block_q, .fail_valid,
      .fail_in, .replace_req_q, .ecc_req_q, .query_block, .query_bad_q);
   nand_autoread_model #(.PAGES(4)) nand_autoread_model_inst (.sys_clk, .power_rst(sys_rst),
      .seq_option(seq_enable), .mark_bad, .ce_n(ce_n_q), .re_n(re_n_q), .rb_n, .io(io_in));

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cycles++;
      if (sys_rst) n_bad = 0;
      else if (bad_event_q === 1'b1) n_bad++;
      if (cycles == 40000) begin
         n_fail++;
         complete_run();
      end
   end

   task automatic complete_run();
      if (n_fail == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check(string what, logic [10:0] exp, logic [10:0] got);
      compares++;
      if (got !== exp) begin
         $display("unexpected %s expected %h seen %h", what, exp, got);
         n_fail++;
      end
   endtask
   function automatic logic [8:0] expect_word(int p, int i);
      logic [7:0] d;
      d = 8'(i + p * 7);
      if (i == 517) d = (mark_bad && p == 0) ? 8'h00 : 8'hFF;
      return {d, i == 527};
   endfunction
   task automatic power_up(logic seq, logic bad);
      sys_rst = 1'b1;
      seq_enable = seq;
      mark_bad = bad;
      repeat (16) @(negedge sys_clk);
      sys_rst = 1'b0;
   endtask
   task automatic read_words(int p, int first, int n);
      int w;
      for (int i = first; i < first + n; i++) begin
         w = 0;
         while (word_valid !== 1'b1 && w < 3000) begin
            @(negedge sys_clk);
            w++;
         end
         check("word", 11'(expect_word(p, i)), 11'(word_out));
         @(negedge sys_clk);
      end
   endtask

   task automatic run_single_page();
      power_up(1'b0, 1'b0);
      read_words(0, 0, 10);
      check("pins", 11'h008, {6'h00, ce_n_q, we_n_q, cle_q, ale_q, io_oe_q});
      check("bus_out", 11'h000, 11'(io_out_q));
      read_words(0, 10, 518);
      repeat (300) @(negedge sys_clk);
      check("extra", 11'h000, {9'h000, word_valid, scan_done_q});
      check("bad_count", 11'h000, 11'(n_bad));
   endtask
   task automatic run_stall_seq();
      power_up(1'b1, 1'b0);
      word_ready = 1'b0;
      repeat (300) @(negedge sys_clk);
      lows = 0;
      repeat (20) begin
         @(negedge sys_clk);
         if (re_n_q !== 1'b1) lows++;
      end
      check("stall_pulses", 11'h000, 11'(lows));
      word_ready = 1'b1;
      for (int p = 0; p < 4; p++) read_words(p, 0, 528);
      repeat (10) @(negedge sys_clk);
      check("scan_done", 11'h002, {9'h000, scan_done_q, word_valid});
   endtask
   task automatic run_bad_marker();
      power_up(1'b0, 1'b1);
      read_words(0, 0, 528);
      repeat (5) @(negedge sys_clk);
      check("bad_event", 11'h001, 11'(n_bad));
      check("bad_block", 11'h000, bad_block_q);
      query_block = '0;
      @(negedge sys_clk);
      check("query_marker", 11'h001, {10'h000, query_bad_q});
   endtask
   task automatic run_fails();
      for (int k = 0; k < 3; k++) begin
         fail_in = '{kind: fail_kind_e'(k), block: BLOCK_W'(5 + k)};
         fail_valid = 1'b1;
         @(negedge sys_clk);
         check("fail_reaction", (k == 0) ? 11'h001 : 11'h002, {9'h000, replace_req_q, ecc_req_q});
         fail_valid = 1'b0;
         query_block = BLOCK_W'(5 + k);
         @(negedge sys_clk);
         check("query_fail", 11'(k != 0), {10'h000, query_bad_q});
      end
   endtask
   task automatic run_stop();
      power_up(1'b1, 1'b0);
      read_words(0, 0, 100);
      stop_req = 1'b1;
      @(negedge sys_clk);
      stop_req = 1'b0;
      @(negedge sys_clk);
      check("stop", 11'h002, {9'h000, ce_n_q, busy_q});
   endtask

   initial begin
      {sys_rst, seq_enable, stop_req, fail_valid, mark_bad} = '0;
      word_ready = 1'b1;
      fail_in = '0;
      query_block = '0;
      run_single_page();
      run_stall_seq();
      run_bad_marker();
      run_fails();
      run_stop();
      complete_run();
   end
endmodule
